// >>> logic/gpi_top.sv
// generator protection: mains decoupling latch, over-current warning, three idmt curves
// assumes currents arrive with a one-cycle valid strobe, buttons are clean levels
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

module gpi_top
    import gpi_pkg::*;
#(
    parameter int SPC         = 10,
    parameter int DECAY_SH    = 10,
    parameter int HOLD_CYCLES = HOLD_MS * CLK_KHZ
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire gpi_wb_t     wb,
    output logic [31:0]      wb_rdata,
    output logic             wb_ack,
    input  wire gpi_meas_t   meas,
    input  wire gpi_mains_t  mains,
    input  wire gpi_btn_t    btn,
    output logic             breaker_trip,
    output logic             shutdown,
    output logic             warn_alarm,
    output logic             irq
);

    typedef struct packed {
        logic                      ack;
        logic [31:0]               rdat;
        logic [9:0]                ctrl;
        logic [CHN-1:0][15:0]      trip;
        logic [CHN-1:0][15:0]      mult;
        logic [NIRQ-1:0]           imask;
        logic [NIRQ-1:0]           istat;
        logic                      dec;
        logic                      warn;
        logic [CHN-1:0]            alm;
        logic                      brk;
        logic                      shd;
        logic                      irq;
        logic [31:0]               hold;
        logic [CHN-1:0][63:0]      acc;
    } gpi_state_t;

    gpi_state_t           q;
    gpi_state_t           n;
    logic [15:0]          imax;
    logic [CHN-1:0][15:0] cur;
    logic [CHN-1:0]       over;
    logic [CHN-1:0][63:0] inc;
    logic [CHN-1:0][63:0] unity;
    logic [CHN-1:0][63:0] sum;
    logic [CHN-1:0]       en;
    logic [CHN-1:0]       act;
    logic [CHN-1:0]       fire;
    logic                 req;
    logic                 wr;
    logic                 both;
    logic                 combo;
    logic                 dec_ev;
    logic                 dec_clr;
    logic                 warn_set;
    logic                 warn_drop;
    logic [NIRQ-1:0]      ev;
    logic [NIRQ-1:0]      w1c;
    logic [31:0]          rd;

    // log2 in q12; bend term cuts the straight-mantissa error to a few thousandths
    function automatic logic [15:0] gpi_log2(input logic [15:0] x);
        logic [3:0]  p;
        logic [15:0] s;
        logic [11:0] f;
        logic [25:0] m;
        logic [22:0] k;
        p = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (x[i]) begin
                p = 4'(i);
            end
        end
        s = x << (4'hf - p);
        f = s[14:3];
        m = 26'(f) * 26'(13'h1000 - 13'(f));
        k = 23'(m[23:12]) * 23'(LOG_CORR);
        return {p, 12'h000} + 16'(f) + 16'(k[22:12]);
    endfunction : gpi_log2

    function automatic logic [15:0] gpi_wm16(input logic [15:0] o,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : gpi_wm16

    // heaviest phase drives both phase curves
    always_comb begin
        imax = meas.l1;
        if (meas.l2 > imax) begin
            imax = meas.l2;
        end
        if (meas.l3 > imax) begin
            imax = meas.l3;
        end
    end

    assign cur[CH_OC] = imax;
    assign cur[CH_SC] = imax;
    assign cur[CH_EF] = meas.ef;

    for (genvar c = 0; c < CHN; c++) begin : g_ch
        assign over[c] = cur[c] > q.trip[c];
        assign sum[c]  = q.acc[c] + inc[c];
        assign act[c]  = q.ctrl[B_ACT0+c];
        if (c == CH_OC) begin : g_oc
            logic [15:0] ex;
            // (ia-it)^2 per sample against it^2 * t * samples per second
            assign ex       = cur[c] - q.trip[c];
            assign inc[c]   = 64'(ex) * 64'(ex);
            assign unity[c] = 64'(q.trip[c]) * 64'(q.trip[c])
                              * 64'(q.mult[c]) * 64'(SPC);
            assign en[c]    = q.ctrl[B_EN0+c];
        end else begin : g_inv
            logic [15:0] d;
            logic [25:0] y;
            logic [15:0] yq;
            logic [31:0] yy;
            // ratio^0.02-1 = e^y-1 with y small, so y + y*y/2 suffices
            assign d        = gpi_log2(cur[c]) - gpi_log2(q.trip[c]);
            assign y        = 26'(d) * 26'(LN2_K);
            assign yq       = 16'(y[25:12]);
            assign yy       = 32'(yq) * 32'(yq);
            assign inc[c]   = 64'(yq) + 64'(yy[31:17]);
            assign unity[c] = 64'(q.mult[c]) * 64'(SPC) * 64'(K014);
            if (c == CH_EF) begin : g_ef
                assign en[c] = q.ctrl[B_EN0+c] & meas.ef_ct;
            end else begin : g_sc
                assign en[c] = q.ctrl[B_EN0+c];
            end
        end
    end

    assign req   = wb.cyc & wb.stb;
    // write lands on the edge where the master sees ack
    assign wr    = req & q.ack & wb.we;
    assign both  = btn.mute & btn.accept;
    assign combo = both & (q.hold == 32'(HOLD_CYCLES - 1));

    always_comb begin
        n         = q;
        rd        = 32'h0000_0000;
        w1c       = '0;
        fire      = '0;
        n.ack     = req & ~q.ack;

        // register read, unmapped reads as zero
        if (wb.adr == A_CTRL) begin
            rd = 32'(q.ctrl);
        end else if (wb.adr == A_STAT) begin
            rd[S_DEC]              = q.dec;
            rd[S_WARN]             = q.warn;
            rd[S_ALM0+:CHN]        = q.alm;
            rd[S_PAR]              = mains.par;
            rd[S_BRK]              = q.brk;
            rd[S_SHD]              = q.shd;
        end else if (wb.adr == A_ISTAT) begin
            rd = 32'(q.istat);
        end else if (wb.adr == A_IMASK) begin
            rd = 32'(q.imask);
        end else begin
            for (int c = 0; c < CHN; c++) begin
                if (wb.adr == A_TRIP0 + 8'(c) * A_STEP) begin
                    rd = 32'(q.trip[c]);
                end
                if (wb.adr == A_MULT0 + 8'(c) * A_STEP) begin
                    rd = 32'(q.mult[c]);
                end
            end
        end
        if (req & ~q.ack) begin
            n.rdat = rd;
        end

        // register write
        if (wr) begin
            if (wb.adr == A_CTRL) begin
                n.ctrl = 10'(gpi_wm16({6'h00, q.ctrl}, wb.wdata, wb.sel));
            end else if (wb.adr == A_ISTAT) begin
                w1c = wb.sel[0] ? wb.wdata[NIRQ-1:0] : '0;
            end else if (wb.adr == A_IMASK) begin
                if (wb.sel[0]) begin
                    n.imask = wb.wdata[NIRQ-1:0];
                end
            end else begin
                for (int c = 0; c < CHN; c++) begin
                    if (wb.adr == A_TRIP0 + 8'(c) * A_STEP) begin
                        n.trip[c] = gpi_wm16(q.trip[c], wb.wdata, wb.sel);
                    end
                    if (wb.adr == A_MULT0 + 8'(c) * A_STEP) begin
                        n.mult[c] = gpi_wm16(q.mult[c], wb.wdata, wb.sel);
                    end
                end
            end
        end

        // mute+accept hold timer saturates so the clear fires once per press
        if (!both) begin
            n.hold = 32'h0000_0000;
        end else if (q.hold != 32'(HOLD_CYCLES)) begin
            n.hold = q.hold + 32'h0000_0001;
        end

        // mains decoupling, new fault wins over a clear in the same cycle
        dec_ev  = mains.par & ((q.ctrl[B_ROCOF] & mains.rocof)
                               | (q.ctrl[B_VS] & mains.vs));
        dec_clr = btn.stop | btn.clr_dec | combo;
        n.dec   = dec_ev | (q.dec & ~dec_clr);

        // immediate warning
        warn_set  = q.ctrl[B_OCW] & meas.vld
                    & (imax >= q.trip[CH_OC]);
        warn_drop = ~q.ctrl[B_OCW] | btn.stop
                    | (meas.vld & ~q.ctrl[B_LATCH]
                       & (imax < q.trip[CH_OC]));
        n.warn    = warn_set | (q.warn & ~warn_drop);

        // inverse curves
        for (int c = 0; c < CHN; c++) begin
            if (!en[c]) begin
                n.acc[c] = 64'h0;
            end else if (meas.vld) begin
                if (over[c]) begin
                    n.acc[c] = sum[c];
                    fire[c]  = sum[c] >= unity[c];
                end else begin
                    n.acc[c] = q.acc[c] - (q.acc[c] >> DECAY_SH);
                end
            end
            n.alm[c] = fire[c] | (q.alm[c] & ~btn.stop);
        end

        // trip actions
        n.brk = n.dec | (|(n.alm & act));
        n.shd = |(n.alm & ~act);

        // sticky events, a new event beats a same-cycle clear
        ev      = {n.alm & ~q.alm, n.warn & ~q.warn, n.dec & ~q.dec};
        n.istat = (q.istat & ~w1c) | ev;
        n.irq   = |(n.istat & n.imask);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q       <= '0;
            q.ctrl  <= CTRL_RST;
            q.trip  <= {CHN{TRIP_RST}};
            q.mult  <= {CHN{MULT_RST}};
            q.imask <= IMASK_RST;
        end else begin
            q <= n;
        end
    end

    assign wb_rdata     = q.rdat;
    assign wb_ack       = q.ack;
    assign breaker_trip = q.brk;
    assign shutdown     = q.shd;
    assign warn_alarm   = q.warn;
    assign irq          = q.irq;

endmodule : gpi_top

// >>> logic/gpi_pkg.sv
// constants, field positions and carrier types of the generator protection block
// assumes one 100 MHz clock and a classic wishbone master with 32-bit data
package gpi_pkg;

    localparam int CLK_KHZ = 100000;
    localparam int HOLD_MS = 500;
    localparam int CHN     = 3;
    localparam int CH_OC   = 0;
    localparam int CH_SC   = 1;
    localparam int CH_EF   = 2;

    // byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_TRIP0  = 8'h04;
    localparam logic [7:0] A_MULT0  = 8'h08;
    localparam logic [7:0] A_STEP   = 8'h08;
    localparam logic [7:0] A_STAT   = 8'h1c;
    localparam logic [7:0] A_ISTAT  = 8'h20;
    localparam logic [7:0] A_IMASK  = 8'h24;

    // control bits; enable and action of channel c at B_EN0+c, B_ACT0+c
    localparam int B_ROCOF = 0;
    localparam int B_VS    = 1;
    localparam int B_OCW   = 2;
    localparam int B_LATCH = 3;
    localparam int B_EN0   = 4;
    localparam int B_ACT0  = 7;

    // status and interrupt bits
    localparam int S_DEC  = 0;
    localparam int S_WARN = 1;
    localparam int S_ALM0 = 2;
    localparam int S_PAR  = 5;
    localparam int S_BRK  = 6;
    localparam int S_SHD  = 7;
    localparam int NIRQ   = 5;

    localparam logic [9:0]  CTRL_RST  = 10'h000;
    localparam logic [15:0] TRIP_RST  = 16'hffff;
    localparam logic [15:0] MULT_RST  = 16'h0064;
    localparam logic [4:0]  IMASK_RST = 5'h00;

    // 0.02*ln2 and 0.14 in q16, log2 mantissa bend in q12
    localparam logic [9:0]  LN2_K    = 10'h38d;
    localparam logic [13:0] K014     = 14'h23d7;
    localparam logic [10:0] LOG_CORR = 11'h571;

    typedef struct packed {
        logic        vld;
        logic        ef_ct;
        logic [15:0] l1;
        logic [15:0] l2;
        logic [15:0] l3;
        logic [15:0] ef;
    } gpi_meas_t;

    typedef struct packed {
        logic par;
        logic rocof;
        logic vs;
    } gpi_mains_t;

    typedef struct packed {
        logic stop;
        logic clr_dec;
        logic mute;
        logic accept;
    } gpi_btn_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] wdata;
    } gpi_wb_t;

endpackage : gpi_pkg

// >>> verif/gpi_front.sv
// current front end model: one sample strobe every PER cycles
// lines invert off strobe; only strobed values may be trusted
`timescale 1ns/1ps
module gpi_front
    import gpi_pkg::*;
#(parameter int PER = 2) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] iph,
    input  wire logic [15:0] ief,
    input  wire logic        ct,
    output gpi_meas_t        meas
);
    int          c_q;
    logic [1:0]  ph_q;
    logic [15:0] m;
    always_ff @(posedge mclk) begin
        c_q <= (rst || c_q == PER - 1) ? 0 : c_q + 1;
        // heaviest phase rotates so every line gets to lead
        if (rst || (meas.vld && ph_q == 2'h2)) ph_q <= 2'h0;
        else if (meas.vld) ph_q <= ph_q + 2'h1;
    end
    always_comb begin
        meas.vld = c_q == PER - 1 && !rst;
        m = {16{!meas.vld}};
        meas.ef_ct = ct;
        meas.l1 = (ph_q == 2'h0 ? iph : iph >> 1) ^ m;
        meas.l2 = (ph_q == 2'h1 ? iph : iph >> 1) ^ m;
        meas.l3 = (ph_q == 2'h2 ? iph : iph >> 1) ^ m;
        meas.ef = ief ^ m;
    end
endmodule : gpi_front

// >>> verif/gpi_top_monitor.sv
// port checker: bus answer, decoupling latch, immediate warning
// assumes full-word writes; ctrl and oc trip are shadowed from the bus
`timescale 1ns/1ps
module gpi_top_monitor
    import gpi_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire gpi_wb_t     wb,
    input wire logic [31:0] wb_rdata,
    input wire logic        wb_ack,
    input wire gpi_meas_t   meas,
    input wire gpi_mains_t  mains,
    input wire gpi_btn_t    btn,
    input wire logic        breaker_trip,
    input wire logic        shutdown,
    input wire logic        warn_alarm,
    input wire logic        irq
);
    logic [9:0]  ctl_q;
    logic [15:0] trp_q;
    logic        wr;
    logic        hi;
    assign wr = wb.cyc && wb.stb && wb.we && wb_ack;
    assign hi = meas.l1 >= trp_q || meas.l2 >= trp_q || meas.l3 >= trp_q;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_q <= CTRL_RST;
            trp_q <= TRIP_RST;
        end else if (wr && wb.adr == A_CTRL) ctl_q <= wb.wdata[9:0];
        else if (wr && wb.adr == A_TRIP0) trp_q <= wb.wdata[15:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_req; wb.cyc && wb.stb && !wb_ack; endsequence
    sequence s_pulse; wb_ack ##1 !wb_ack; endsequence
    a_bus_answer: assert property (s_req |=> s_pulse)
        else $error("no one-cycle ack");
    a_ack_cause: assert property ($rose(wb_ack) |-> $past(wb.cyc && wb.stb))
        else $error("ack without request");
    a_dec_trip: assert property (mains.par && (mains.rocof && ctl_q[B_ROCOF]
        || mains.vs && ctl_q[B_VS]) |=> breaker_trip) else $error("no decoupling trip");
    // ctrl writes may retarget alarm actions, so they are left out
    a_trip_holds: assert property (breaker_trip && !btn.stop && !btn.clr_dec
        && !btn.mute && !wr && !$past(wr) |=> breaker_trip) else $error("trip lost");
    a_warn_rise: assert property (meas.vld && ctl_q[B_OCW] && hi && !wr
        |=> warn_alarm) else $error("no warning");
    a_warn_drop: assert property (warn_alarm && meas.vld && !hi && !wr
        && !ctl_q[B_LATCH] |=> !warn_alarm) else $error("warning stuck");
    a_warn_latch: assert property (warn_alarm && ctl_q[B_LATCH] && ctl_q[B_OCW]
        && !btn.stop && !wr |=> warn_alarm) else $error("latched warning lost");
    a_warn_off: assert property (!ctl_q[B_OCW] && !wr |=> !warn_alarm)
        else $error("warning while disabled");
endmodule : gpi_top_monitor

bind gpi_top gpi_top_monitor mon (.mclk(mclk), .rst(rst), .wb(wb), .wb_rdata(wb_rdata),
    .wb_ack(wb_ack), .meas(meas), .mains(mains), .btn(btn), .breaker_trip(breaker_trip),
    .shutdown(shutdown), .warn_alarm(warn_alarm), .irq(irq));

// >>> verif/tb_gpi_top.sv
// self-checking bench of the protection block; reads checked from a queue
// assumes gpi_front as current source, mute+accept hold cut to 8 cycles
`timescale 1ns/1ps
module tb_gpi_top;
    import gpi_pkg::*;
    localparam int SPC = 10;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    gpi_wb_t     wb = '0;
    gpi_mains_t  mains = '0;
    gpi_btn_t    btn = '0;
    logic [15:0] iph = 16'h0;
    logic [15:0] ief = 16'h0;
    logic        ct = 1'b0;
    gpi_meas_t   meas;
    logic [31:0] wb_rdata;
    logic        wb_ack, breaker_trip, shutdown, warn_alarm, irq;
    logic [31:0] expq[$];
    logic [3:0]  clr[3] = '{4'h4, 4'h8, 4'h3};
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          n;
    real         e, d;
    always #5 mclk = ~mclk;
    gpi_front #(.PER(2)) fe (.mclk(mclk), .rst(rst), .iph(iph), .ief(ief), .ct(ct),
        .meas(meas));
    gpi_top #(.SPC(SPC), .HOLD_CYCLES(8)) dut (.mclk(mclk), .rst(rst), .wb(wb),
        .wb_rdata(wb_rdata), .wb_ack(wb_ack), .meas(meas), .mains(mains), .btn(btn),
        .breaker_trip(breaker_trip), .shutdown(shutdown), .warn_alarm(warn_alarm),
        .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    always @(posedge mclk) if (wb_ack === 1'b1 && !wb.we) begin
        if (expq.size() == 0) chk(wb_rdata, 32'hdead);
        else chk(wb_rdata, expq.pop_front());
    end
    task automatic cy(input int k);
        repeat (k) @(posedge mclk);
    endtask : cy
    // no fixed latency assumed: wait for ack under a bound
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        int t;
        t = 0;
        wb <= '{1'b1, 1'b1, w, a, 4'hf, v};
        do begin
            @(posedge mclk);
            t++;
        end while (wb_ack !== 1'b1 && t < 50);
        // a bus that never answers ends the run here
        if (wb_ack !== 1'b1) begin
            chk(32'h0, 32'h1);
            results();
        end
        wb <= '0;
        @(posedge mclk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        expq.push_back(v);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // outputs are looked at mid-cycle, well clear of the launching edge
    task automatic co(input logic [31:0] v);
        cy(4);
        @(negedge mclk);
        chk({28'h0, irq, breaker_trip, shutdown, warn_alarm}, v);
        @(posedge mclk);
    endtask : co
    task automatic tt(input logic b, output int k);
        k = 0;
        while ((b ? breaker_trip : shutdown) !== 1'b1 && k < 3000) begin
            @(posedge mclk);
            k += int'(meas.vld);
        end
    endtask : tt
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        #200_000;
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(32'ha2b5));
        cy(3);
        rst <= 1'b0;
        cy(1);
        rd(A_CTRL, {22'h0, CTRL_RST});
        rd(A_TRIP0, {16'h0, TRIP_RST});
        rd(A_MULT0, {16'h0, MULT_RST});
        rd(A_IMASK, {27'h0, IMASK_RST});
        rd(8'h30, 32'h0);
        wr(A_CTRL, 32'h3);
        mains <= 3'h3;
        co(32'h0);
        for (int k = 0; k < 3; k++) begin
            mains <= k[0] ? 3'h5 : 3'h6;
            co(32'h4);
            mains <= 3'h0;
            co(32'h4);
            rd(A_STAT, 32'h41);
            btn <= clr[k];
            cy(10);
            co(32'h0);
            btn <= 4'h0;
        end
        wr(A_ISTAT, 32'h1f);
        wr(A_CTRL, 32'h4);
        wr(A_TRIP0, 32'h64);
        wr(A_IMASK, 32'h2);
        iph <= 16'h64 + 16'($urandom % 300);
        co(32'h9);
        rd(A_ISTAT, 32'h2);
        iph <= 16'($urandom % 100);
        co(32'h8);
        wr(A_ISTAT, 32'h2);
        co(32'h0);
        wr(A_CTRL, 32'hc);
        iph <= 16'h64;
        co(32'h9);
        iph <= 16'h0;
        co(32'h9);
        wr(A_IMASK, 32'h0);
        btn <= 4'h8;
        co(32'h0);
        btn <= 4'h0;
        wr(A_MULT0, 32'h5);
        wr(A_CTRL, 32'h10);
        iph <= 16'hc8;
        tt(1'b0, n);
        chk({31'h0, n > 5 * SPC - 2 && n < 5 * SPC + 2}, 32'h1);
        iph <= 16'h0;
        btn <= 4'h8;
        cy(2);
        btn <= 4'h0;
        wr(A_CTRL, 32'h0);
        wr(A_CTRL, 32'h10);
        iph <= 16'hc8;
        cy(50);
        iph <= 16'h0;
        cy(20);
        iph <= 16'hc8;
        tt(1'b0, n);
        chk({31'h0, n > 0 && n < 5 * SPC - 5}, 32'h1);
        iph <= 16'h0;
        btn <= 4'h8;
        cy(2);
        btn <= 4'h0;
        for (int k = 1; k < 3; k++) begin
            wr(A_CTRL, 32'h0);
            wr(A_TRIP0 + 8'(8 * k), 32'h64);
            wr(A_MULT0 + 8'(8 * k), 32'ha);
            wr(A_CTRL, 32'h120 << (k - 1));
            if (k == 2) begin
                ief <= 16'h12c;
                cy(1500);
                co(32'h0);
                ct <= 1'b1;
            end else iph <= 16'hc8;
            e = 10.0 * SPC * 0.14 / (real'(k + 1) ** 0.02 - 1.0);
            tt(1'b1, n);
            d = (real'(n) > e) ? real'(n) - e : e - real'(n);
            d = d - ((0.05 * e > 5.0 * SPC) ? 0.05 * e : 5.0 * SPC);
            chk({31'h0, d <= 0.0}, 32'h1);
            iph <= 16'h0;
            ief <= 16'h0;
            btn <= 4'h8;
            cy(2);
            btn <= 4'h0;
        end
        cy(4);
        results();
    end
endmodule : tb_gpi_top
